// ### hw/dsm_port.sv
// Top of the dual serial modem port: eight-wire primary and four-wire secondary.
//
// Behaviour
// R1: Two asynchronous serial ports face the host, an eight-line primary and a four-line secondary.
// R2: Both ports use RS-232 style data and control signalling between module and host.
// R3: Secondary flow control uses only the host ready input and the device clear output, sampled before sending.
// R4: The secondary clear output tells the host whether it may transmit toward the module.
// R5: Lines are named from the host side, so host transmit is a device input and host receive a device output.
// R6: The ring indicator output pulses for incoming calls and short messages.
// R7: While terminal-ready is held low the device never enters sleep.
// R8: Terminal-ready switches the primary port between data mode and command mode.
// R9: Activity on terminal-ready wakes the device from sleep.
// R10: Carrier detect is asserted for as long as a data connection is in progress.
// R11: Data-set-ready is asserted whenever the primary interface is switched on.
// R12: The full primary port and the wireless coexistence function exclude each other.
// R13: With wake monitoring on, any level change of terminal-ready during sleep wakes the device.
// R14: Frames are one start bit, eight data bits, no parity and one stop bit at a configurable rate.
`timescale 1ns/100ps
`include "dsm_consts.svh"
module dsm_port #(
	parameter int DIV_W       = 16,
	parameter int RING_CYCLES = `DSM_RING_CYCLES
) (
	input  wire logic               i_clk,
	input  wire logic               i_sys_rst,
	input  wire logic [DIV_W-1:0]   i_baud_div,
	input  wire dsm_pkg::dsm_ctrl_t i_ctrl,
	input  wire logic               i_primary_host_tx_in,
	input  wire logic               i_primary_host_ready_in,
	input  wire logic               i_terminal_ready_in_n,
	input  wire logic               i_secondary_host_tx_in,
	input  wire logic               i_secondary_host_ready_in,
	input  wire dsm_pkg::dsm_beat_t i_pri_tx,
	input  wire dsm_pkg::dsm_beat_t i_sec_tx,
	input  wire logic               i_pri_rx_ready,
	input  wire logic               i_sec_rx_ready,
	output logic                    o_primary_host_rx_out,
	output logic                    o_primary_clear_out,
	output logic                    o_ring_indicator_out,
	output logic                    o_carrier_detect_out,
	output logic                    o_data_set_ready_out,
	output logic                    o_secondary_host_rx_out,
	output logic                    o_secondary_clear_out,
	output logic                    o_pri_tx_ready,
	output logic                    o_sec_tx_ready,
	output dsm_pkg::dsm_beat_t      o_pri_rx,
	output dsm_pkg::dsm_beat_t      o_sec_rx,
	output logic                    o_command_mode,
	output logic                    o_coex_granted,
	output logic                    o_sleep,
	output logic                    o_wake_pulse
);
	logic               pri_en;
	logic               pri_line;
	logic               sec_line;
	logic               pri_tx_rdy;
	logic               sec_tx_rdy;
	logic               pri_go;
	logic               sec_go;
	logic               sec_rx_busy;
	logic               dtr_q;
	logic               dtr_edge;
	logic               ring_req_q;
	logic [31:0]        ring_cnt_q;
	dsm_pkg::dsm_beat_t pri_rx_b;
	dsm_pkg::dsm_beat_t sec_rx_b;
	dsm_pkg::dsm_pwr_t  pwr_q;

	// The primary port owns its pins only while coexistence is not holding them.
	assign pri_en = i_ctrl.primary_on && !o_coex_granted; // [R12]

	// Primary sends only while on and the host signals ready.
	assign pri_go = i_pri_tx.valid && pri_en && i_primary_host_ready_in; // [R2]

	// Host ready is looked at before a character starts; a frame in flight completes. [R3]
	assign sec_go = i_sec_tx.valid && i_secondary_host_ready_in; // [R3]

	// Primary serial engines; host transmit is our input, host receive our output. [R5]
	dsm_tx #(.DIV_W(DIV_W)) u_pri_tx (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_div     (i_baud_div),
		.i_valid   (pri_go),
		.i_data    (i_pri_tx.data),
		.o_ready   (pri_tx_rdy),
		.o_line    (pri_line)
	);

	dsm_rx #(.DIV_W(DIV_W)) u_pri_rx (
		.i_clk       (i_clk),
		.i_sys_rst   (i_sys_rst),
		.i_div       (i_baud_div),
		.i_line      (pri_en ? i_primary_host_tx_in : `DSM_LINE_IDLE),
		.o_beat      (pri_rx_b),
		.o_frame_err (),
		.o_busy      ()
	);

	// Secondary serial engines. [R1]
	dsm_tx #(.DIV_W(DIV_W)) u_sec_tx (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_div     (i_baud_div),
		.i_valid   (sec_go),
		.i_data    (i_sec_tx.data),
		.o_ready   (sec_tx_rdy),
		.o_line    (sec_line)
	);

	dsm_rx #(.DIV_W(DIV_W)) u_sec_rx (
		.i_clk       (i_clk),
		.i_sys_rst   (i_sys_rst),
		.i_div       (i_baud_div),
		.i_line      (i_secondary_host_tx_in),
		.o_beat      (sec_rx_b),
		.o_frame_err (),
		.o_busy      (sec_rx_busy)
	);

	// Serial data pins and user-side handshakes, registered for clean outputs.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_primary_host_rx_out   <= `DSM_LINE_IDLE;
			o_secondary_host_rx_out <= `DSM_LINE_IDLE;
			o_pri_tx_ready          <= 1'b0;
			o_sec_tx_ready          <= 1'b0;
			o_pri_rx                <= '0;
			o_sec_rx                <= '0;
		end
		else
		begin
			o_primary_host_rx_out   <= pri_en ? pri_line : `DSM_LINE_IDLE; // [R5]
			o_secondary_host_rx_out <= sec_line; // [R5]
			o_pri_tx_ready          <= pri_tx_rdy && pri_go;
			o_sec_tx_ready          <= sec_tx_rdy && sec_go;
			o_pri_rx                <= pri_rx_b;
			o_sec_rx                <= sec_rx_b;
		end
	end

	// Clear outputs are active high here; the user side holds clear low while it has no room.
	// Secondary clear also drops while a character is being received, a conservative pacing.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_primary_clear_out   <= 1'b0;
			o_secondary_clear_out <= 1'b0;
		end
		else
		begin
			o_primary_clear_out   <= pri_en && i_pri_rx_ready;
			o_secondary_clear_out <= i_sec_rx_ready && !sec_rx_busy; // [R4]
		end
	end

	// Modem status lines: carrier follows the call, set-ready follows the port power.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_carrier_detect_out <= 1'b0;
			o_data_set_ready_out <= 1'b0;
		end
		else
		begin
			o_carrier_detect_out <= pri_en && i_ctrl.call_active; // [R10]
			o_data_set_ready_out <= pri_en; // [R11]
		end
	end

	// Coexistence is granted only while the primary port is off, so both never run together.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_coex_granted <= 1'b0;
		else
			o_coex_granted <= i_ctrl.coex_req && !i_ctrl.primary_on; // [R12]
	end

	// Ring pulse: each rising request while the primary port is enabled starts a fixed-length pulse, extended if re-requested.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			ring_req_q           <= 1'b0;
			ring_cnt_q           <= '0;
			o_ring_indicator_out <= 1'b0;
		end
		else
		begin
			ring_req_q <= i_ctrl.ring_req;
			if (i_ctrl.ring_req && !ring_req_q && pri_en)
			begin
				ring_cnt_q           <= 32'(RING_CYCLES - 1);
				o_ring_indicator_out <= 1'b1; // [R6]
			end
			else if (ring_cnt_q != '0)
				ring_cnt_q <= ring_cnt_q - 32'h1;
			else
				o_ring_indicator_out <= 1'b0; // [R6]
		end
	end

	// Terminal-ready history for edge detection; low means asserted.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			dtr_q <= `DSM_DTR_RELEASED;
		else
			dtr_q <= i_terminal_ready_in_n;
	end

	assign dtr_edge = (dtr_q != i_terminal_ready_in_n);

	// Deasserted terminal-ready puts the port in command mode, asserted gives data mode.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_command_mode <= `DSM_DTR_RELEASED;
		else
			o_command_mode <= i_terminal_ready_in_n; // [R8]
	end

	// Power state: sleep only on request with terminal-ready released; asserted terminal-ready wakes, and any edge wakes with wake monitoring on.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			pwr_q        <= dsm_pkg::DSM_PWR_AWAKE;
			o_sleep      <= 1'b0;
			o_wake_pulse <= 1'b0;
		end
		else
		begin
			o_wake_pulse <= 1'b0;
			unique case (pwr_q)
				dsm_pkg::DSM_PWR_AWAKE:
					if (i_ctrl.sleep_req && i_terminal_ready_in_n && !dtr_edge) // [R7]
					begin
						pwr_q   <= dsm_pkg::DSM_PWR_SLEEP;
						o_sleep <= 1'b1;
					end
				dsm_pkg::DSM_PWR_SLEEP:
					if ((i_ctrl.wake_monitor && dtr_edge) || !i_terminal_ready_in_n) // [R9] [R13]
					begin
						pwr_q        <= dsm_pkg::DSM_PWR_AWAKE;
						o_sleep      <= 1'b0;
						o_wake_pulse <= 1'b1;
					end
				default:
					pwr_q <= dsm_pkg::DSM_PWR_AWAKE; // An unused code falls back to awake rather than hang.
			endcase
		end
	end
endmodule : dsm_port

// ### hw/dsm_rx.sv
// Serial receiver: samples mid-bit, checks the stop bit.
`timescale 1ns/100ps
`include "dsm_consts.svh"
module dsm_rx #(
	parameter int DIV_W = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	input  wire logic [DIV_W-1:0] i_div,
	input  wire logic             i_line,
	output dsm_pkg::dsm_beat_t    o_beat,
	output logic                  o_frame_err,
	output logic                  o_busy
);
	dsm_pkg::dsm_ser_t st_q;
	logic [DIV_W-1:0]  cnt_q;
	logic [2:0]        bit_q;
	logic [7:0]        sh_q;
	logic              line_q;
	logic              mid;
	logic              tick;

	// Line is taken as synchronous; one register stage aids timing only.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			line_q <= `DSM_LINE_IDLE;
		else
			line_q <= i_line;
	end

	assign mid    = (cnt_q == (i_div >> 1));
	assign tick   = (cnt_q >= i_div);
	assign o_busy = (st_q != dsm_pkg::DSM_SER_IDLE);

	// Bit timing counter; the start state uses the half point to centre sampling.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			cnt_q <= '0;
		else if (st_q == dsm_pkg::DSM_SER_IDLE || tick || (st_q == dsm_pkg::DSM_SER_START && mid))
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + 1'b1;
	end

	// Frame sequencer; a missing stop bit drops the byte and flags it.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			st_q        <= dsm_pkg::DSM_SER_IDLE;
			bit_q       <= '0;
			sh_q        <= `DSM_BYTE_ZERO;
			o_beat      <= '0;
			o_frame_err <= 1'b0;
		end
		else
		begin
			o_beat.valid <= 1'b0;
			o_frame_err  <= 1'b0;
			unique case (st_q)
				dsm_pkg::DSM_SER_IDLE:
					if (line_q == `DSM_START_LVL)
						st_q <= dsm_pkg::DSM_SER_START;
				dsm_pkg::DSM_SER_START:
					if (mid)
					begin
						bit_q <= '0;
						st_q  <= (line_q == `DSM_START_LVL) ? dsm_pkg::DSM_SER_DATA : dsm_pkg::DSM_SER_IDLE;
					end
				dsm_pkg::DSM_SER_DATA:
					if (tick)
					begin
						sh_q  <= {line_q, sh_q[7:1]};
						bit_q <= bit_q + 3'h1;
						if (bit_q == `DSM_LAST_BIT)
							st_q <= dsm_pkg::DSM_SER_STOP;
					end
				dsm_pkg::DSM_SER_STOP:
					if (tick)
					begin
						if (line_q == `DSM_STOP_LVL) // [R14]
						begin
							o_beat.valid <= 1'b1;
							o_beat.data  <= sh_q;
						end
						else
							o_frame_err <= 1'b1;
						st_q <= dsm_pkg::DSM_SER_IDLE;
					end
			endcase
		end
	end
endmodule : dsm_rx

// ### hw/dsm_tx.sv
// Serial transmitter: one start bit, eight data bits, one stop bit.
`timescale 1ns/100ps
`include "dsm_consts.svh"
module dsm_tx #(
	parameter int DIV_W = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	input  wire logic [DIV_W-1:0] i_div,
	input  wire logic             i_valid,
	input  wire logic [7:0]       i_data,
	output logic                  o_ready,
	output logic                  o_line
);
	dsm_pkg::dsm_ser_t st_q;
	logic [DIV_W-1:0]  cnt_q;
	logic [2:0]        bit_q;
	logic [7:0]        sh_q;
	logic              tick;

	// One bit period has elapsed when the counter reaches the divisor.
	assign tick = (cnt_q >= i_div);
	assign o_ready = (st_q == dsm_pkg::DSM_SER_IDLE);

	// Bit timing counter, restarted on every bit boundary.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			cnt_q <= '0;
		else if (st_q == dsm_pkg::DSM_SER_IDLE || tick)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + 1'b1;
	end

	// Frame sequencer and line driver, registered so the pin is glitch free.
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			st_q   <= dsm_pkg::DSM_SER_IDLE;
			bit_q  <= '0;
			sh_q   <= `DSM_BYTE_ZERO;
			o_line <= `DSM_LINE_IDLE;
		end
		else
		begin
			unique case (st_q)
				dsm_pkg::DSM_SER_IDLE:
					if (i_valid)
					begin
						sh_q   <= i_data;
						o_line <= `DSM_START_LVL; // [R14]
						st_q   <= dsm_pkg::DSM_SER_START;
					end
				dsm_pkg::DSM_SER_START:
					if (tick)
					begin
						o_line <= sh_q[0];
						sh_q   <= {1'b0, sh_q[7:1]};
						bit_q  <= '0;
						st_q   <= dsm_pkg::DSM_SER_DATA;
					end
				dsm_pkg::DSM_SER_DATA:
					if (tick)
					begin
						if (bit_q == `DSM_LAST_BIT)
						begin
							o_line <= `DSM_STOP_LVL; // [R14]
							st_q   <= dsm_pkg::DSM_SER_STOP;
						end
						else
						begin
							o_line <= sh_q[0];
							sh_q   <= {1'b0, sh_q[7:1]};
							bit_q  <= bit_q + 3'h1;
						end
					end
				dsm_pkg::DSM_SER_STOP:
					if (tick)
						st_q <= dsm_pkg::DSM_SER_IDLE;
			endcase
		end
	end
endmodule : dsm_tx

// ### shared/dsm_consts.svh
// Timing and framing constants for the dual serial modem port.
`ifndef DSM_CONSTS_SVH
`define DSM_CONSTS_SVH
`define DSM_CLK_HZ        125000000
`define DSM_BAUD_DEF      115200
`define DSM_DATA_BITS     8
`define DSM_RING_MS       1
`define DSM_RING_CYCLES   ((`DSM_CLK_HZ / 1000) * `DSM_RING_MS)
`define DSM_LINE_IDLE     1'b1
`define DSM_START_LVL     1'b0
`define DSM_STOP_LVL      1'b1
`define DSM_BYTE_ZERO     8'h00
`define DSM_LAST_BIT      3'h7
`define DSM_DTR_RELEASED  1'b1
`endif

// ### shared/dsm_pkg.sv
// Types shared by the dual serial modem port design.
package dsm_pkg;
	// Byte stream beat with handshake.
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} dsm_beat_t;

	// Modem-side controls from the module core.
	typedef struct packed {
		logic ring_req;
		logic call_active;
		logic primary_on;
		logic coex_req;
		logic sleep_req;
		logic wake_monitor;
	} dsm_ctrl_t;

	// Power state of the module as seen by the port.
	typedef enum logic [1:0] {
		DSM_PWR_AWAKE = 2'b00,
		DSM_PWR_SLEEP = 2'b01
	} dsm_pwr_t;

	// Serial engine state.
	typedef enum logic [1:0] {
		DSM_SER_IDLE  = 2'b00,
		DSM_SER_START = 2'b01,
		DSM_SER_DATA  = 2'b10,
		DSM_SER_STOP  = 2'b11
	} dsm_ser_t;
endpackage : dsm_pkg

// ### sim/dsm_host_model.sv
// Host serial port model: sends frames on request and decodes frames it receives.
`timescale 1ns/100ps
module dsm_host_model (
	input  wire logic        i_clk,
	input  wire logic [15:0] i_div,
	input  wire logic        i_send,
	input  wire logic [7:0]  i_byte,
	input  wire logic        i_stall,
	input  wire logic        i_rx,
	output logic             o_tx,
	output logic             o_rts,
	output logic             o_got,
	output logic [7:0]       o_got_byte
);
	logic [9:0] tx_sh;
	logic [8:0] rx_sh;
	// Ready is dropped while the host stalls; the device must look before each frame.
	assign o_rts = !i_stall;
	initial o_tx = 1'b1;
	initial o_got = 1'b0;
	// Host transmit line: idle high, start low, LSB first, stop high.
	always @(posedge i_clk)
		if (i_send)
		begin
			tx_sh = {1'b1, i_byte, 1'b0};
			for (int b = 0; b < 10; b++)
			begin
				o_tx <= tx_sh[b];
				repeat (i_div + 1) @(posedge i_clk);
			end
		end
	// Receiver samples mid-bit; a bad stop bit gives no report.
	always
	begin
		@(negedge i_rx);
		repeat ((i_div + 1) / 2) @(posedge i_clk);
		for (int b = 0; b < 9; b++)
		begin
			repeat (i_div + 1) @(posedge i_clk);
			rx_sh = {i_rx, rx_sh[8:1]};
		end
		o_got_byte <= rx_sh[7:0];
		o_got <= rx_sh[8];
		@(posedge i_clk);
		o_got <= 1'b0;
	end
endmodule : dsm_host_model

// ### sim/dsm_port_sva.sv
// Concurrent checks on the ports of the dual serial modem port.
`timescale 1ns/100ps
module dsm_port_sva #(
	parameter int RING_CYCLES = 20
) (
	input wire logic               i_clk,
	input wire logic               i_sys_rst,
	input wire dsm_pkg::dsm_ctrl_t i_ctrl,
	input wire logic               i_terminal_ready_in_n,
	input wire logic               i_secondary_host_ready_in,
	input wire dsm_pkg::dsm_beat_t i_sec_tx,
	input wire logic               i_sec_rx_ready,
	input wire logic               o_ring_indicator_out,
	input wire logic               o_carrier_detect_out,
	input wire logic               o_data_set_ready_out,
	input wire logic               o_secondary_host_rx_out,
	input wire logic               o_secondary_clear_out,
	input wire logic               o_sec_tx_ready,
	input wire logic               o_command_mode,
	input wire logic               o_coex_granted,
	input wire logic               o_sleep,
	input wire logic               o_wake_pulse
);
	logic [31:0] ring_len_q;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// Counts the ring pulse so a cut or stretched pulse shows where it falls.
	always_ff @(posedge i_clk or posedge i_sys_rst)
		if (i_sys_rst)
			ring_len_q <= 32'h0;
		else if (o_ring_indicator_out)
			ring_len_q <= ring_len_q + 32'h1;
		else
			ring_len_q <= 32'h0;
	// A start bit lasts longer than one clock, so a one-cycle dip is caught.
	sequence s_start_bit;
		!o_secondary_host_rx_out ##1 !o_secondary_host_rx_out;
	endsequence
	a_dsr_port_on:
		assert property (i_ctrl.primary_on && !o_coex_granted && !$past(i_sys_rst) |=> o_data_set_ready_out)
			else $error("dsr low");
	a_cd_call_on:
		assert property (o_carrier_detect_out |-> $past(i_ctrl.primary_on && i_ctrl.call_active))
			else $error("cd without call");
	a_ring_cause:
		assert property ($rose(o_ring_indicator_out) |-> $past(i_ctrl.ring_req && i_ctrl.primary_on))
			else $error("ring without request");
	a_ring_length:
		assert property ($fell(o_ring_indicator_out) |-> ring_len_q == RING_CYCLES) else $error("ring length");
	a_sec_take_ready:
		assert property (o_sec_tx_ready |-> $past(i_secondary_host_ready_in && i_sec_tx.valid))
			else $error("send without host ready");
	a_sec_start_bit:
		assert property (o_sec_tx_ready |=> s_start_bit) else $error("no start bit");
	a_sec_clear_gate:
		assert property (o_secondary_clear_out |-> $past(i_sec_rx_ready)) else $error("clear while not ready");
	a_sleep_blocked:
		assert property (!i_terminal_ready_in_n |=> !o_sleep) else $error("sleep while terminal ready");
	a_wake_pulse_on:
		assert property ($fell(o_sleep) |-> o_wake_pulse) else $error("wake without pulse");
	a_wake_any_edge:
		assert property (o_sleep && i_ctrl.wake_monitor && $changed(i_terminal_ready_in_n) |=> !o_sleep)
			else $error("edge did not wake");
	a_cmd_mode_follow:
		assert property ($changed(i_terminal_ready_in_n) && !$past(i_sys_rst)
			|=> o_command_mode == $past(i_terminal_ready_in_n)) else $error("mode not switched");
	a_coex_exclusive:
		assert property (o_coex_granted |-> !o_data_set_ready_out && $past(i_ctrl.coex_req))
			else $error("coex with primary");
endmodule : dsm_port_sva

bind dsm_port dsm_port_sva #(.RING_CYCLES(RING_CYCLES)) i_dsm_port_sva (.*);

// ### sim/tb_top.sv
// Self-checking testbench for the dual serial modem port.
`timescale 1ns/100ps
module tb_top;
	localparam logic [15:0] DIV = 16'h0003;
	logic               clk, rst, term_n, pri_rdy, sec_rdy;
	dsm_pkg::dsm_ctrl_t ctrl;
	dsm_pkg::dsm_beat_t pri_tx, sec_tx, pri_rx, sec_rx;
	logic               p_send, s_send, p_stall, s_stall, p_htx, s_htx, p_rts, s_rts, p_got, s_got;
	logic [7:0]         p_byte, s_byte, p_gb, s_gb;
	logic               pri_line, pri_clr, ring, cd, dsr, sec_line, sec_clr, pri_acc, sec_acc;
	logic               cmd, coex, sleep, wake;
	int                 n_mismatch = 0;
	int                 check_count = 0;

	dsm_port #(.RING_CYCLES(20)) i_dsm_port (.i_clk(clk), .i_sys_rst(rst), .i_baud_div(DIV), .i_ctrl(ctrl),
		.i_primary_host_tx_in(p_htx), .i_primary_host_ready_in(p_rts), .i_terminal_ready_in_n(term_n),
		.i_secondary_host_tx_in(s_htx), .i_secondary_host_ready_in(s_rts), .i_pri_tx(pri_tx), .i_sec_tx(sec_tx),
		.i_pri_rx_ready(pri_rdy), .i_sec_rx_ready(sec_rdy), .o_primary_host_rx_out(pri_line),
		.o_primary_clear_out(pri_clr), .o_ring_indicator_out(ring), .o_carrier_detect_out(cd),
		.o_data_set_ready_out(dsr), .o_secondary_host_rx_out(sec_line), .o_secondary_clear_out(sec_clr),
		.o_pri_tx_ready(pri_acc), .o_sec_tx_ready(sec_acc), .o_pri_rx(pri_rx), .o_sec_rx(sec_rx),
		.o_command_mode(cmd), .o_coex_granted(coex), .o_sleep(sleep), .o_wake_pulse(wake));
	dsm_host_model u_pri_host (.i_clk(clk), .i_div(DIV), .i_send(p_send), .i_byte(p_byte), .i_stall(p_stall),
		.i_rx(pri_line), .o_tx(p_htx), .o_rts(p_rts), .o_got(p_got), .o_got_byte(p_gb));
	dsm_host_model u_sec_host (.i_clk(clk), .i_div(DIV), .i_send(s_send), .i_byte(s_byte), .i_stall(s_stall),
		.i_rx(sec_line), .o_tx(s_htx), .o_rts(s_rts), .o_got(s_got), .o_got_byte(s_gb));

	// The clock runs at 125 MHz.
	always #4 clk = ~clk;

	task automatic chk1(input string name, input logic exp, input logic got);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : chk1

	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : chk8

	// Holds valid until the accept pulse is seen, then drops it at the clock edge that ends that pulse.
	task automatic dev_send(input bit sec, input logic [7:0] b);
		int n;
		n = 0;
		@(posedge clk);
		if (sec)
			sec_tx <= {1'b1, b};
		else
			pri_tx <= {1'b1, b};
		do
		begin
			@(posedge clk);
			n++;
		end
		while ((sec ? sec_acc : pri_acc) !== 1'b1 && n < 400);
		chk1("byte taken", 1'b1, sec ? sec_acc : pri_acc);
		pri_tx.valid <= 1'b0;
		sec_tx.valid <= 1'b0;
	endtask : dev_send

	task automatic wait_got(input bit sec, input logic [7:0] exp);
		int n;
		n = 0;
		while ((sec ? s_got : p_got) !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		chk1("host byte seen", 1'b1, sec ? s_got : p_got);
		chk8("host byte", exp, sec ? s_gb : p_gb);
	endtask : wait_got

	task automatic host_send(input bit sec, input logic [7:0] b);
		int n;
		n = 0;
		@(posedge clk);
		p_send <= !sec;
		s_send <= sec;
		p_byte <= b;
		s_byte <= b;
		@(posedge clk);
		p_send <= 1'b0;
		s_send <= 1'b0;
		while ((sec ? sec_rx.valid : pri_rx.valid) !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		chk1("device byte seen", 1'b1, sec ? sec_rx.valid : pri_rx.valid);
		chk8("device byte", b, sec ? sec_rx.data : pri_rx.data);
	endtask : host_send

	task automatic t_status();
		@(posedge clk);
		ctrl.coex_req <= 1'b1;
		ctrl.call_active <= 1'b1;
		repeat (3) @(posedge clk);
		chk1("carrier detect", 1'b1, cd);
		chk1("coex grant", 1'b0, coex);
		ctrl.primary_on <= 1'b0;
		repeat (3) @(posedge clk);
		chk1("data set ready", 1'b0, dsr);
		chk1("carrier detect", 1'b0, cd);
		chk1("coex grant", 1'b1, coex);
		ctrl <= 6'h08;
		repeat (3) @(posedge clk);
	endtask : t_status

	task automatic t_ring();
		int n;
		n = 0;
		@(posedge clk);
		ctrl.ring_req <= 1'b1;
		while (ring !== 1'b1 && n < 10)
		begin
			@(posedge clk);
			n++;
		end
		n = 0;
		while (ring === 1'b1 && n < 100)
		begin
			@(posedge clk);
			n++;
		end
		ctrl.ring_req <= 1'b0;
		chk8("ring width", 8'h14, n[7:0]);
	endtask : t_ring

	task automatic t_sec_flow();
		int n;
		n = 0;
		@(posedge clk);
		s_stall <= 1'b1;
		sec_tx <= {1'b1, 8'h5a};
		repeat (60)
		begin
			@(posedge clk);
			n += (sec_acc === 1'b1);
		end
		chk8("takes while stalled", 8'h00, n[7:0]);
		s_stall <= 1'b0;
		dev_send(1'b1, 8'h5a);
		wait_got(1'b1, 8'h5a);
	endtask : t_sec_flow

	task automatic t_clear();
		@(posedge clk);
		sec_rdy <= 1'b0;
		pri_rdy <= 1'b0;
		repeat (3) @(posedge clk);
		chk1("secondary clear", 1'b0, sec_clr);
		chk1("primary clear", 1'b0, pri_clr);
		sec_rdy <= 1'b1;
		pri_rdy <= 1'b1;
		repeat (3) @(posedge clk);
		chk1("secondary clear", 1'b1, sec_clr);
		chk1("primary clear", 1'b1, pri_clr);
	endtask : t_clear

	task automatic t_sleep();
		int n;
		n = 0;
		@(posedge clk);
		term_n <= 1'b1;
		ctrl.wake_monitor <= 1'b1;
		repeat (3) @(posedge clk);
		chk1("command mode", 1'b1, cmd);
		ctrl.sleep_req <= 1'b1;
		repeat (4) @(posedge clk);
		chk1("sleep", 1'b1, sleep);
		term_n <= 1'b0;
		ctrl.sleep_req <= 1'b0;
		repeat (4)
		begin
			@(posedge clk);
			n += (wake === 1'b1);
		end
		chk8("wake pulses", 8'h01, n[7:0]);
		chk1("sleep", 1'b0, sleep);
		chk1("command mode", 1'b0, cmd);
		ctrl.sleep_req <= 1'b1;
		repeat (4) @(posedge clk);
		chk1("sleep", 1'b0, sleep);
		ctrl.sleep_req <= 1'b0;
	endtask : t_sleep

	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	// Main sequence: reset for ten cycles, then every scenario in turn.
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		ctrl = 6'h08;
		term_n = 1'b0;
		{pri_rdy, sec_rdy} = 2'h3;
		{pri_tx, sec_tx} = '0;
		{p_send, s_send, p_stall, s_stall} = 4'h0;
		{p_byte, s_byte} = 16'h0000;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk1("data set ready", 1'b1, dsr);
		t_status();
		t_ring();
		dev_send(1'b0, 8'ha5);
		wait_got(1'b0, 8'ha5);
		dev_send(1'b0, 8'h3c);
		wait_got(1'b0, 8'h3c);
		t_sec_flow();
		host_send(1'b0, 8'h81);
		host_send(1'b1, 8'h7e);
		t_clear();
		t_sleep();
		close_out();
	end

	// The run needs well under a thousand cycles; a hang ends it here.
	initial
	begin
		#(5000 * 8);
		n_mismatch++;
		close_out();
	end
endmodule : tb_top
